/* File: rtl/pip_ingress_ctrl.sv */
// Added by the designer: register access over Wishbone.
`timescale 1ns/1ps
`include "pip_map.svh"

// Functional notes
// [RL1] mode 01 blocks: authentication on, acl misses blocked, hits take actions
// [RL2] mode 10 passes: authentication off, acl misses forwarded, hits take actions
// [RL3] mode 11 traps: authentication on, traffic to host, acl misses blocked
// [RL4] bit 2 of authentication register reads acl enable, read only, one means on
// [RL5] pointer bits 18:16 hold the port index, reset zero
// [RL6] pointer bits 1:0 hold the queue pointer, reset zero
// [RL7] map holds eight 4-bit fields, low two bits are the queue
// [RL8] map resets to priorities 0,1->q0 2,3->q1 4,5->q2 6,7->q3
// [RL9] police bit 0 enables policing and wred, reset off
// [RL10] police bit 1 set is colour blind, clear colour aware
// [RL11] police bit 2 lets wred drop stream reservation packets
// [RL12] police bit 3 remaps dscp colour in aware mode, else dscp colour used
// [RL13] police bit 4 enables dscp colour marking
// [RL14] police bits 6:5 give non-ip frame colour, reset 01
// [RL15] police bit 7 set is per port per queue, clear uses port zero
// [RL16] police bits 9:8 choose which colour counter reads back
// [RL17] police bit 10 drops all while memory maximum threshold exceeded
// [RL18] police bit 11 makes colour counters count dropped packets only
// [RL19] rate settings apply to the pointed queue of the pointed port
// [RL20] reserved and read-only bits ignore writes and read zero or status
// [RL21] software loads port index and queue pointer before indirect access
module pip_ingress_ctrl #(
  parameter int CNT_W = 24
) (
  // clock and reset
  input  wire logic             i_clk_sys,
  input  wire logic             i_resetn,
  // wishbone classic slave
  input  wire logic             i_wb_cyc,
  input  wire logic             i_wb_stb,
  input  wire logic             i_wb_we,
  input  wire logic [15:0]      i_wb_adr,
  input  wire logic [31:0]      i_wb_dat,
  input  wire logic [3:0]       i_wb_sel,
  output logic                  o_wb_ack,
  output logic [31:0]           o_wb_dat,
  // status from the acl engine
  input  wire logic             i_acl_enable,
  // per-colour packet counters of the pointed port and queue
  input  wire logic [CNT_W-1:0] i_perf_monitor_count_drop,
  input  wire logic [CNT_W-1:0] i_perf_monitor_count_green,
  input  wire logic [CNT_W-1:0] i_perf_monitor_count_yellow,
  input  wire logic [CNT_W-1:0] i_perf_monitor_count_red,
  // ingress frame descriptor
  input  wire logic             i_frm_valid,
  input  wire logic             i_frm_acl_hit,
  input  wire logic [2:0]       i_frm_prio,
  input  wire logic             i_frm_is_ip,
  input  wire logic [1:0]       i_frm_dscp_color,
  input  wire logic [1:0]       i_frm_remap_color,
  input  wire logic             i_frm_srp,
  // frame verdict, one cycle after the descriptor
  output logic                  o_frm_valid,
  output logic                  o_frm_auth_on,
  output logic                  o_frm_forward,
  output logic                  o_frm_block,
  output logic                  o_frm_to_host,
  output logic                  o_frm_acl_action,
  output logic [1:0]            o_frm_queue,
  output logic [1:0]            o_frm_color,
  output logic                  o_frm_mark,
  output logic                  o_frm_police,
  output logic                  o_frm_wred_drop_ok,
  // policing configuration to the meter and wred engines
  output logic                  o_police_en,
  output logic                  o_color_blind,
  output logic                  o_drop_all,
  output logic                  o_count_dropped_only,
  output logic [1:0]            o_perf_monitor_count_select,
  output logic [2:0]            o_rate_port,
  output logic [1:0]            o_rate_queue
);

  // merge a masked write into a register, keeping read-only bits
  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] wd,
                                        input logic [31:0] lanes,
                                        input logic [31:0] wrable);
    logic [31:0] m;
    m = lanes & wrable;
    merge = (old & ~m) | (wd & m);
  endfunction : merge

  pip_reg_if rif ();

  pip_wb_slave u_bus (
    .i_clk_sys (i_clk_sys),
    .i_resetn  (i_resetn),
    .i_wb_cyc  (i_wb_cyc),
    .i_wb_stb  (i_wb_stb),
    .i_wb_we   (i_wb_we),
    .i_wb_adr  (i_wb_adr),
    .i_wb_dat  (i_wb_dat),
    .i_wb_sel  (i_wb_sel),
    .o_wb_ack  (o_wb_ack),
    .o_wb_dat  (o_wb_dat),
    .rif       (rif)
  );

  // stored registers
  logic [31:0] auth_q;
  logic [31:0] ptr_q;
  logic [31:0] map_q;
  logic [31:0] police_q;
  logic        acl_en_q;

  // address decode
  wire hit_auth   = (rif.idx == `PIP_IDX_AUTH);
  wire hit_ptr    = (rif.idx == `PIP_IDX_PTR);
  wire hit_map    = (rif.idx == `PIP_IDX_MAP);
  wire hit_police = (rif.idx == `PIP_IDX_POLICE);
  wire hit_perf_monitor_count   = (rif.idx == `PIP_IDX_PERF_MONITOR_COUNT);

  // next register values; only writable bits take the data
  wire [31:0] auth_d   = merge(auth_q, rif.wdata, rif.wmask,
                               `PIP_WR_AUTH);           // [RL20]
  wire [31:0] ptr_d    = merge(ptr_q, rif.wdata, rif.wmask,
                               `PIP_WR_PTR);            // [RL5] [RL6] [RL20]
  wire [31:0] map_d    = merge(map_q, rif.wdata, rif.wmask,
                               `PIP_WR_MAP);            // [RL7] [RL20]
  wire [31:0] police_d = merge(police_q, rif.wdata, rif.wmask,
                               `PIP_WR_POLICE);         // [RL20]

  // configuration fields
  wire pip_pkg::pip_auth_type auth_mode =
    pip_pkg::pip_auth_type'(auth_q[1:0]);
  wire [2:0] port_idx  = ptr_q[`PIP_PTR_PORT_LSB +: 3];          // [RL5]
  wire [1:0] queue_ptr = ptr_q[`PIP_PTR_QUEUE_LSB +: 2];         // [RL6]
  wire       pol_en    = police_q[`PIP_POL_EN_BIT];              // [RL9]
  wire       pol_blind = police_q[`PIP_POL_BLIND_BIT];           // [RL10]
  wire       pol_srp   = police_q[`PIP_POL_SRP_BIT];             // [RL11]
  wire       pol_remap = police_q[`PIP_POL_REMAP_BIT];           // [RL12]
  wire       pol_mark  = police_q[`PIP_POL_MARK_BIT];            // [RL13]
  wire [1:0] pol_nonip = police_q[`PIP_POL_NONIP_LSB +: 2];      // [RL14]
  wire       pol_pport = police_q[`PIP_POL_PERPORT_BIT];         // [RL15]
  wire [1:0] pol_pmsel = police_q[`PIP_POL_PMSEL_LSB +: 2];      // [RL16]
  wire       pol_dall  = police_q[`PIP_POL_DROPALL_BIT];         // [RL17]
  wire       pol_dcnt  = police_q[`PIP_POL_DROPCNT_BIT];         // [RL18]

  // counter chosen by the colour counter select field, police bits 9:8
  logic [CNT_W-1:0] perf_monitor_count_sel;
  always_comb begin
    case (pip_pkg::pip_color_type'(pol_pmsel))
      pip_pkg::PIP_CLR_RED:    perf_monitor_count_sel = i_perf_monitor_count_red;       // [RL16]
      pip_pkg::PIP_CLR_YELLOW: perf_monitor_count_sel = i_perf_monitor_count_yellow;    // [RL16]
      pip_pkg::PIP_CLR_GREEN:  perf_monitor_count_sel = i_perf_monitor_count_green;     // [RL16]
      default:                 perf_monitor_count_sel = i_perf_monitor_count_drop;      // [RL16]
    endcase
  end

  // authentication register shows live acl status in bit 2
  wire [31:0] auth_rd = {auth_q[31:3], acl_en_q, auth_q[1:0]};  // [RL4]

  // read mux; unmapped indices read zero
  assign rif.rdata = hit_auth   ? auth_rd :
                     hit_ptr    ? ptr_q :
                     hit_map    ? map_q :
                     hit_police ? police_q :
                     hit_perf_monitor_count   ? 32'(perf_monitor_count_sel) :
                                  32'h0000_0000;

  // register bank
  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      auth_q   <= `PIP_RST_AUTH;
      ptr_q    <= `PIP_RST_PTR;
      map_q    <= `PIP_RST_MAP;                          // [RL8]
      police_q <= `PIP_RST_POLICE;                       // [RL9] [RL14]
      acl_en_q <= 1'b0;                                  // [RL4]
    end else begin
      acl_en_q <= i_acl_enable;                          // [RL4]
      if (rif.wr && hit_auth)   auth_q   <= auth_d;
      if (rif.wr && hit_ptr)    ptr_q    <= ptr_d;
      if (rif.wr && hit_map)    map_q    <= map_d;
      if (rif.wr && hit_police) police_q <= police_d;
    end
  end

  // authentication and acl verdict for the incoming frame
  logic v_auth_on;
  logic v_block;
  logic v_forward;
  logic v_to_host;
  logic v_acl_action;

  pip_auth_decode u_auth (
    .i_mode       (auth_mode),
    .i_acl_en     (acl_en_q),
    .i_acl_hit    (i_frm_acl_hit),
    .o_auth_on    (v_auth_on),
    .o_block      (v_block),
    .o_forward    (v_forward),
    .o_to_host    (v_to_host),
    .o_acl_action (v_acl_action)
  );

  // egress queue from the priority map
  wire [4:0] map_lsb = {i_frm_prio, 2'b00};
  wire [1:0] queue_d = map_q[map_lsb +: 2];              // [RL7]

  // colour: blind or disabled policing starts green
  wire [1:0] ip_color = pol_remap ? i_frm_remap_color    // [RL12]
                                  : i_frm_dscp_color;
  wire [1:0] aware_c  = i_frm_is_ip ? ip_color
                                    : pol_nonip;         // [RL14]
  wire [1:0] color_d  = (pol_en && !pol_blind)           // [RL10]
                      ? aware_c : 2'(pip_pkg::PIP_CLR_GREEN);

  // with policing on, wred may drop unless the frame is srp and srp drops are off
  wire drop_ok_d = pol_en & (~i_frm_srp | pol_srp);      // [RL11]

  // rate entry: port zero holds aggregate rates when not per port
  wire [2:0] rate_port_d = pol_pport ? port_idx : 3'h0;  // [RL15] [RL19]

  // frame verdict stage
  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      o_frm_valid        <= 1'b0;
      o_frm_auth_on      <= 1'b0;
      o_frm_forward      <= 1'b0;
      o_frm_block        <= 1'b0;
      o_frm_to_host      <= 1'b0;
      o_frm_acl_action   <= 1'b0;
      o_frm_queue        <= 2'h0;
      o_frm_color        <= 2'h0;
      o_frm_mark         <= 1'b0;
      o_frm_police       <= 1'b0;
      o_frm_wred_drop_ok <= 1'b0;
    end else begin
      o_frm_valid        <= i_frm_valid;
      o_frm_auth_on      <= v_auth_on;                   // [RL1] [RL2] [RL3]
      o_frm_forward      <= v_forward;                   // [RL2]
      o_frm_block        <= v_block;                     // [RL1] [RL3]
      o_frm_to_host      <= v_to_host;                   // [RL3]
      o_frm_acl_action   <= v_acl_action;
      o_frm_queue        <= queue_d;                     // [RL7]
      o_frm_color        <= color_d;
      o_frm_mark         <= pol_mark & i_frm_is_ip;      // [RL13]
      o_frm_police       <= pol_en;                      // [RL9]
      o_frm_wred_drop_ok <= drop_ok_d;                   // [RL11]
    end
  end

  // configuration to the meter, wred and counter engines
  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      o_police_en          <= 1'b0;
      o_color_blind        <= 1'b0;
      o_drop_all           <= 1'b0;
      o_count_dropped_only <= 1'b0;
      o_perf_monitor_count_select        <= 2'h0;
      o_rate_port          <= 3'h0;
      o_rate_queue         <= 2'h0;
    end else begin
      o_police_en          <= pol_en;                    // [RL9]
      o_color_blind        <= pol_blind;                 // [RL10]
      o_drop_all           <= pol_dall;                  // [RL17]
      o_count_dropped_only <= pol_dcnt;                  // [RL18]
      o_perf_monitor_count_select        <= pol_pmsel;                 // [RL16]
      o_rate_port          <= rate_port_d;               // [RL19]
      o_rate_queue         <= queue_ptr;                 // [RL19] [RL21]
    end
  end

endmodule : pip_ingress_ctrl

/* File: rtl/pip_map.svh */
`ifndef PIP_MAP_SVH
`define PIP_MAP_SVH

// register indices; byte address on the bus is four times the index
`define PIP_IDX_AUTH        14'h0803
`define PIP_IDX_PTR         14'h0804
`define PIP_IDX_MAP         14'h0808
`define PIP_IDX_POLICE      14'h080c
`define PIP_IDX_PERF_MONITOR_COUNT        14'h0810

// writable bits of each register
`define PIP_WR_AUTH         32'h0000_0003
`define PIP_WR_PTR          32'h0007_0003
`define PIP_WR_MAP          32'h3333_3333
`define PIP_WR_POLICE       32'h0000_0fff

// reset values
`define PIP_RST_AUTH        32'h0000_0000
`define PIP_RST_PTR         32'h0000_0000
`define PIP_RST_MAP         32'h3322_1100
`define PIP_RST_POLICE      32'h0000_0020

// field positions
`define PIP_AUTH_ACL_BIT    2
`define PIP_PTR_PORT_LSB    16
`define PIP_PTR_QUEUE_LSB   0
`define PIP_POL_EN_BIT      0
`define PIP_POL_BLIND_BIT   1
`define PIP_POL_SRP_BIT     2
`define PIP_POL_REMAP_BIT   3
`define PIP_POL_MARK_BIT    4
`define PIP_POL_NONIP_LSB   5
`define PIP_POL_PERPORT_BIT 7
`define PIP_POL_PMSEL_LSB   8
`define PIP_POL_DROPALL_BIT 10
`define PIP_POL_DROPCNT_BIT 11

`endif

/* File: rtl/pip_pkg.sv */
package pip_pkg;

  // authentication mode field encoding
  typedef enum logic [1:0] {
    PIP_AUTH_RSVD,
    PIP_AUTH_BLOCK,
    PIP_AUTH_PASS,
    PIP_AUTH_TRAP
  } pip_auth_type;

  // colour code, shared by the counter select field
  typedef enum logic [1:0] {
    PIP_CLR_DROP,
    PIP_CLR_GREEN,
    PIP_CLR_YELLOW,
    PIP_CLR_RED
  } pip_color_type;

endpackage : pip_pkg

/* File: rtl/pip_reg_if.sv */
`timescale 1ns/1ps
// register access between the bus slave and the register bank
interface pip_reg_if;
  logic        wr;     // one-cycle write pulse
  logic [13:0] idx;    // word index
  logic [31:0] wdata;
  logic [31:0] wmask;  // byte lanes expanded to bits
  logic [31:0] rdata;
  modport bus  (output wr, idx, wdata, wmask, input rdata);
  modport regs (input wr, idx, wdata, wmask, output rdata);
endinterface : pip_reg_if

/* File: rtl/pip_wb_slave.sv */
`timescale 1ns/1ps
module pip_wb_slave (
  // clock and reset
  input  wire logic        i_clk_sys,
  input  wire logic        i_resetn,
  // wishbone classic slave
  input  wire logic        i_wb_cyc,
  input  wire logic        i_wb_stb,
  input  wire logic        i_wb_we,
  input  wire logic [15:0] i_wb_adr,
  input  wire logic [31:0] i_wb_dat,
  input  wire logic [3:0]  i_wb_sel,
  output logic             o_wb_ack,
  output logic [31:0]      o_wb_dat,
  // register side
  pip_reg_if.bus           rif
);

  // expand byte enables into a bit mask
  function automatic logic [31:0] lane_mask(input logic [3:0] sel);
    lane_mask = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
  endfunction : lane_mask

  logic        ack_q;
  logic [31:0] dat_q;
  wire         req   = i_wb_cyc & i_wb_stb;
  wire         first = req & ~ack_q;

  // write lands on the edge where the master sees ack
  assign rif.wr    = req & i_wb_we & ack_q;
  assign rif.idx   = i_wb_adr[15:2];
  assign rif.wdata = i_wb_dat;
  assign rif.wmask = lane_mask(i_wb_sel);
  assign o_wb_ack  = ack_q;
  assign o_wb_dat  = dat_q;

  // ack one cycle after request, dropped the cycle after
  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      ack_q <= 1'b0;
      dat_q <= 32'h0000_0000;
    end else begin
      ack_q <= first;
      if (first) dat_q <= i_wb_we ? 32'h0000_0000 : rif.rdata;
    end
  end

endmodule : pip_wb_slave

/* File: rtl/pip_auth_decode.sv */
`timescale 1ns/1ps
module pip_auth_decode (
  // configuration and status
  input  wire pip_pkg::pip_auth_type i_mode,
  input  wire logic                  i_acl_en,
  // frame lookup result
  input  wire logic                  i_acl_hit,
  // verdict
  output logic                       o_auth_on,
  output logic                       o_block,
  output logic                       o_forward,
  output logic                       o_to_host,
  output logic                       o_acl_action
);

  wire is_block = (i_mode == pip_pkg::PIP_AUTH_BLOCK);
  wire is_trap  = (i_mode == pip_pkg::PIP_AUTH_TRAP);
  wire miss     = i_acl_en & ~i_acl_hit;

  // block and trap keep authentication on, pass turns it off
  assign o_auth_on    = is_block | is_trap;                // [RL1] [RL2] [RL3]
  // an acl hit carries the acl action only while the acl is enabled
  assign o_acl_action = i_acl_en & i_acl_hit;              // [RL1] [RL2] [RL3]
  // a miss blocks in block/trap, forwards in pass
  assign o_block      = (miss & o_auth_on)                 // [RL1] [RL3]
                      | (~i_acl_en & is_block);            // [RL1]
  assign o_forward    = ~o_block;                          // [RL2]
  // trap sends all admitted traffic to the host port
  assign o_to_host    = is_trap & ~o_block;                // [RL3]

endmodule : pip_auth_decode

/* File: test/pip_ingress_ctrl_properties.sv */
`timescale 1ns/1ps
// bus handshake and frame verdict relations seen at the top ports
module pip_ingress_ctrl_properties (
  // clock and reset
  input wire logic       i_clk_sys,
  input wire logic       i_resetn,
  // bus
  input wire logic       i_wb_cyc,
  input wire logic       i_wb_stb,
  input wire logic       i_wb_we,
  input wire logic       o_wb_ack,
  // frame side
  input wire logic       i_acl_enable,
  input wire logic       i_frm_valid,
  input wire logic       i_frm_acl_hit,
  input wire logic       i_frm_is_ip,
  input wire logic       i_frm_srp,
  input wire logic       o_frm_valid,
  input wire logic       o_frm_forward,
  input wire logic       o_frm_block,
  input wire logic       o_frm_to_host,
  input wire logic       o_frm_acl_action,
  input wire logic [1:0] o_frm_color,
  input wire logic       o_frm_mark,
  input wire logic       o_frm_police,
  input wire logic       o_frm_wred_drop_ok,
  // configuration
  input wire logic       o_police_en,
  input wire logic       o_color_blind
);
  // one clock domain
  default clocking cb @(posedge i_clk_sys);
  endclocking
  default disable iff (!i_resetn);

  // a taken request is answered on the next edge, for one cycle only
  AST_ACK_ONE: assert property (
    i_wb_cyc && i_wb_stb && !o_wb_ack |=> o_wb_ack ##1 !o_wb_ack)
    else $error("bus request not answered as a single pulse");
  AST_FWD_BLOCK: assert property (
    $past(i_resetn) |-> o_frm_forward != o_frm_block)
    else $error("forward and block not complementary");
  // acl action needs a hit and the acl enable seen one flop earlier
  AST_ACL_ACT: assert property (
    $past(i_resetn, 2) |-> o_frm_acl_action ==
      ($past(i_frm_acl_hit) && $past(i_acl_enable, 2)))
    else $error("acl action does not follow hit and enable");
  AST_HOST: assert property (
    o_frm_to_host |-> !o_frm_block)
    else $error("blocked frame sent to host");
  AST_POLICE: assert property (
    o_frm_police == o_police_en)
    else $error("frame police flag differs from enable");
  AST_BLIND: assert property (
    $past(i_resetn) && (!o_police_en || o_color_blind)
      |-> o_frm_color == 2'b01)
    else $error("blind or disabled policing gives non green");
  AST_SRP: assert property (
    o_police_en && !$past(i_frm_srp) |-> o_frm_wred_drop_ok)
    else $error("non stream packet not droppable");
  AST_MARK: assert property (
    o_frm_mark |-> $past(i_frm_is_ip))
    else $error("non ip frame marked");
  AST_VALID: assert property (
    $past(i_resetn) |-> o_frm_valid == $past(i_frm_valid))
    else $error("frame valid not delayed by one cycle");
  // enable moves only two edges after an acknowledged write
  AST_CFG_WR: assert property (
    $changed(o_police_en) |-> $past(o_wb_ack && i_wb_we, 2))
    else $error("police enable changed without a write");

  // main scenarios
  COV_HOST: cover property (o_frm_valid && o_frm_to_host);
  COV_MARK: cover property (o_frm_valid && o_frm_mark);
  COV_WRITE: cover property (o_wb_ack && i_wb_we);
endmodule : pip_ingress_ctrl_properties

/* File: test/pip_ingress_ctrl_tb.sv */
`timescale 1ns/1ps
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin num_errors++; \
  $display("mismatch at %0t got %h exp %h", $time, g, e); end end
module pip_ingress_ctrl_tb;
  logic        i_clk_sys, i_resetn, i_wb_cyc, i_wb_stb, i_wb_we, o_wb_ack;
  logic [15:0] i_wb_adr;
  logic [31:0] i_wb_dat, o_wb_dat, rd;
  logic [3:0]  i_wb_sel;
  logic [23:0] i_perf_monitor_count_drop, i_perf_monitor_count_green, i_perf_monitor_count_yellow, i_perf_monitor_count_red;
  logic        i_acl_enable, i_frm_valid, i_frm_acl_hit, i_frm_is_ip;
  logic        i_frm_srp, o_frm_valid, o_frm_auth_on, o_frm_forward;
  logic [2:0]  i_frm_prio, o_rate_port;
  logic [1:0]  i_frm_dscp_color, i_frm_remap_color, o_frm_queue;
  logic [1:0]  o_frm_color, o_perf_monitor_count_select, o_rate_queue;
  logic        o_frm_block, o_frm_to_host, o_frm_acl_action, o_frm_mark;
  logic        o_frm_police, o_frm_wred_drop_ok, o_police_en;
  logic        o_color_blind, o_drop_all, o_count_dropped_only, b;
  int          num_errors = 0, cmp_count = 0, cyc_cnt = 0;
  logic [31:0] pm [4] = '{32'h00a1b2c3, 32'h00d4e5f6, 32'h00123456,
                          32'h00fedcba};
  logic [31:0] pv [5] = '{32'h61, 32'h61, 32'h7d, 32'h3, 32'h10};
  logic [4:0]  ex [5] = '{5'b11001, 5'b10011, 5'b11111, 5'b01001, 5'b01100};

  pip_ingress_ctrl #(.CNT_W(24)) uut (.*);

  // counter values offered to the readback register
  assign i_perf_monitor_count_drop   = pm[0][23:0];
  assign i_perf_monitor_count_green  = pm[1][23:0];
  assign i_perf_monitor_count_yellow = pm[2][23:0];
  assign i_perf_monitor_count_red    = pm[3][23:0];

  // clock and hang guard
  always #12.5 i_clk_sys = ~i_clk_sys;
  always @(posedge i_clk_sys) begin
    cyc_cnt++;
    if (cyc_cnt == 5000) begin
      num_errors++;
      final_report();
    end
  end

  // one classic cycle, held until ack is sampled
  task automatic wb(input logic [15:0] a, input logic w,
                    input logic [31:0] d, input logic [3:0] s);
    int n;
    n = 0;
    @(posedge i_clk_sys);
    {i_wb_cyc, i_wb_stb, i_wb_we} <= {2'b11, w};
    i_wb_adr <= a;
    i_wb_dat <= d;
    i_wb_sel <= s;
    do begin
      @(posedge i_clk_sys);
      n++;
    end while (o_wb_ack !== 1'b1 && n < 20);
    if (n == 20) num_errors++; // missing answer counts as a mismatch
    rd = o_wb_dat;
    {i_wb_cyc, i_wb_stb, i_wb_we} <= 3'b000;
  endtask : wb

  task automatic wr(input logic [15:0] a, input logic [31:0] d);
    wb(a, 1'b1, d, 4'hf);
  endtask : wr

  task automatic rchk(input logic [15:0] a, input logic [31:0] e);
    wb(a, 1'b0, 32'h0, 4'hf);
    `CHK(rd, e)
  endtask : rchk

  // one descriptor; verdict checked half a cycle after it lands
  task automatic frm(input logic h, input logic [2:0] p, input logic ip,
                     input logic srp);
    @(posedge i_clk_sys);
    {i_frm_valid, i_frm_acl_hit, i_frm_prio, i_frm_is_ip} <= {1'b1, h, p, ip};
    {i_frm_dscp_color, i_frm_remap_color, i_frm_srp} <= {4'b1011, srp};
    @(posedge i_clk_sys);
    i_frm_valid <= 1'b0;
    @(negedge i_clk_sys);
    `CHK(o_frm_valid, 1'b1)
  endtask : frm

  // every priority against the given map
  task automatic qchk(input logic [31:0] m);
    for (int p = 0; p < 8; p++) begin
      frm(1'b0, 3'(p), 1'b1, 1'b0);
      `CHK(o_frm_queue, 2'(m >> (4 * p)))
    end
  endtask : qchk

  task automatic final_report();
    $display("comparisons %0d mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : final_report

  // test sequence
  initial begin
    i_clk_sys = 1'b0;
    i_resetn = 1'b0;
    {i_wb_cyc, i_wb_stb, i_wb_we, i_acl_enable} = 4'h0;
    {i_wb_adr, i_wb_dat, i_wb_sel} = '0;
    {i_frm_valid, i_frm_acl_hit, i_frm_prio, i_frm_is_ip} = '0;
    {i_frm_dscp_color, i_frm_remap_color, i_frm_srp} = '0;
    repeat (5) @(posedge i_clk_sys);
    i_resetn <= 1'b1;
    rchk(16'h200c, 32'h0);
    rchk(16'h2010, 32'h0);
    rchk(16'h2020, 32'h3322_1100);
    rchk(16'h2030, 32'h0000_0020);
    qchk(32'h3322_1100);
    $display("test reset values done");
    wr(16'h200c, 32'hffff_ffff);
    rchk(16'h200c, 32'h3);
    wr(16'h2010, 32'hffff_ffff);
    rchk(16'h2010, 32'h0007_0003);
    wr(16'h2030, 32'hffff_ffff);
    rchk(16'h2030, 32'h0000_0fff);
    wr(16'h2020, 32'hffff_ffff);
    rchk(16'h2020, 32'h3333_3333);
    wb(16'h2020, 1'b1, 32'h0, 4'h1);
    rchk(16'h2020, 32'h3333_3300);
    wr(16'h2100, 32'hffff_ffff);
    rchk(16'h2100, 32'h0);
    i_acl_enable <= 1'b1;
    rchk(16'h200c, 32'h7);
    wr(16'h2020, 32'h0123_3210);
    qchk(32'h0123_3210);
    $display("test register access done");
    for (int m = 0; m < 4; m++) begin
      wr(16'h200c, 32'(m));
      for (int a = 0; a < 2; a++) begin
        i_acl_enable <= a[0];
        for (int h = 0; h < 2; h++) begin
          frm(h[0], 3'h0, 1'b1, 1'b0);
          b = a[0] ? (h == 0 && m[0]) : (m == 1);
          `CHK({o_frm_block, o_frm_to_host, o_frm_auth_on, o_frm_acl_action}, {b, m == 3 && !b, m[0], a == 1 && h == 1})
        end
      end
    end
    $display("test authentication modes done");
    for (int i = 0; i < 5; i++) begin
      wr(16'h2030, pv[i]);
      frm(1'b1, 3'h0, i != 0, i != 1);
      `CHK({o_frm_color, o_frm_mark, o_frm_wred_drop_ok, o_frm_police}, ex[i])
    end
    $display("test colour and policing done");
    wr(16'h2010, 32'h0005_0003);
    wr(16'h2030, 32'h0000_0d81);
    @(posedge i_clk_sys);
    @(negedge i_clk_sys);
    `CHK({o_rate_port, o_rate_queue, o_drop_all, o_count_dropped_only, o_perf_monitor_count_select, o_police_en}, 10'b101_11_1_1_01_1)
    wr(16'h2030, 32'h0);
    @(posedge i_clk_sys);
    @(negedge i_clk_sys);
    `CHK({o_rate_port, o_rate_queue}, 5'b000_11)
    for (int s = 0; s < 4; s++) begin
      wr(16'h2030, 32'(s) << 8);
      rchk(16'h2040, pm[s]);
    end
    $display("test configuration outputs done");
    final_report();
  end
endmodule : pip_ingress_ctrl_tb

bind pip_ingress_ctrl pip_ingress_ctrl_properties u_props (
  .i_clk_sys(i_clk_sys), .i_resetn(i_resetn), .i_wb_cyc(i_wb_cyc),
  .i_wb_stb(i_wb_stb), .i_wb_we(i_wb_we), .o_wb_ack(o_wb_ack),
  .i_acl_enable(i_acl_enable), .i_frm_valid(i_frm_valid),
  .i_frm_acl_hit(i_frm_acl_hit), .i_frm_is_ip(i_frm_is_ip),
  .i_frm_srp(i_frm_srp), .o_frm_valid(o_frm_valid),
  .o_frm_forward(o_frm_forward), .o_frm_block(o_frm_block),
  .o_frm_to_host(o_frm_to_host), .o_frm_acl_action(o_frm_acl_action),
  .o_frm_color(o_frm_color), .o_frm_mark(o_frm_mark),
  .o_frm_police(o_frm_police), .o_frm_wred_drop_ok(o_frm_wred_drop_ok),
  .o_police_en(o_police_en), .o_color_blind(o_color_blind));
